// File: core/seqio_pkg.sv
// Constants for the sequence terminal allocation and servo gate block
package seqio_pkg;
	// APB register offsets (byte addresses)
	localparam logic [11:0] OFS_CTRL    = 12'h000;
	localparam logic [11:0] OFS_IN_PND  = 12'h004;
	localparam logic [11:0] OFS_OUT_PND = 12'h008;
	localparam logic [11:0] OFS_IN_ACT  = 12'h00c;
	localparam logic [11:0] OFS_OUT_ACT = 12'h010;
	localparam logic [11:0] OFS_ALARM   = 12'h014;
	localparam logic [11:0] OFS_FUNC    = 12'h018;
	localparam logic [11:0] OFS_STAT    = 12'h01c;
	// Field layout
	localparam int IN_W     = 5;
	localparam int OUT_W    = 4;
	localparam int CTRL_REBOOT = 0;
	// Factory allocation: input 1 servo enable, input 2 alarm clear
	localparam logic [24:0] IN_ALLOC_RST  = 25'h0000041;
	// Output 1 ready, 2 positioning done, 3 fault normally closed, 4 none
	localparam logic [15:0] OUT_ALLOC_RST = 16'h0421;
	// Input function codes
	localparam int FN_SERVO_EN = 1;
	localparam int FN_CLEAR    = 2;
	localparam int FN_POS_LIM  = 3;
	localparam int FN_NEG_LIM  = 4;
	localparam int FN_HALT     = 5;
	localparam int FN_LAST     = 21;
	localparam int FN_RSVD     = 22;
	// Level of each function when no terminal carries it
	localparam logic [22:0] FN_DEFAULT = 23'h00013a;
	// Output status codes
	localparam int OC_READY  = 1;
	localparam int OC_SETTLE = 2;
	localparam int OC_FAULT_NO = 3;
	localparam int OC_FAULT_NC = 4;
	localparam int OC_DYN_BRK  = 5;
	localparam int OC_LIMIT    = 6;
	localparam int OC_HALT     = 7;
	localparam int OC_ZERO_DEV = 8;
	localparam int OC_ZERO_SPD = 9;
	localparam int OC_CUR_LIM  = 10;
	localparam int OC_BRK_TIME = 11;
	// Alarm bits: 0..10 cleared by alarm clear, 11..14 by reboot only
	localparam int ALARM_N   = 15;
	localparam int ALARM_DUP = 14;
	localparam logic [14:0] ALARM_CLEARABLE = 15'h07ff;
	// Motion gate states
	typedef enum logic [1:0] {
		MS_COAST = 2'b00,
		MS_RUN   = 2'b01,
		MS_BRAKE = 2'b10,
		MS_HOLD  = 2'b11
	} motion_t;
endpackage : seqio_pkg

// File: core/sequence_io_gate.sv
// Sequence terminal allocation, servo enable gate and alarm latch
// Operation
// - Four output terminals, each allocated a status code 0..13, 0 unused.
// - Output codes 1..11 select ready, settled, faults, brakes, limits, etc.
// - Output codes 12 and 13 are reserved and drive nothing.
// - Factory outputs: ready, settled, fault normally closed, none; apply on reboot.
// - Input codes 1..8: enable, clear, limits, halt, P, dev clear, regen.
// - Input codes 9..21 select the remaining auxiliary functions.
// - Input code 22 is reserved and maps to no function.
// - Factory inputs: terminal 1 servo enable, terminal 2 alarm clear.
// - Motor may rotate only while servo enable is asserted.
// - Rotation commands are discarded while servo enable is off.
// - Enable drop while turning: full brake to zero speed, then coast.
// - Ready needs enable, no alarm, both limits and halt asserted.
// - Enabled but a permissive input inactive: hold the motor stopped.
// - Unallocated servo enable reads as always asserted.
// - Clearable alarms clear on the rising edge of alarm clear.
// - Alarm clear acts on the eleven clearable alarm classes.
// - Encoder, power, memory, duplication alarms clear only on reboot.
// - Unallocated alarm clear reads as always deasserted.
// - Limit detected output is on when either limit input is off.
// - Halt detected output is on when the halt input is off.
// - Unallocated limit inputs read as asserted, no limit active.
//
// Local design decisions: the register addresses and the APB register port.
module sequence_io_gate
	import seqio_pkg::*;
#(
	parameter int N_IN  = 5,
	parameter int N_OUT = 4
) (
	// Clock and reset
	input  wire logic                 REF_CLK_I,
	input  wire logic                 SRST_I,
	// APB slave
	input  wire logic                 PSEL_I,
	input  wire logic                 PENABLE_I,
	input  wire logic                 PWRITE_I,
	input  wire logic [11:0]          PADDR_I,
	input  wire logic [31:0]          PWDATA_I,
	output logic      [31:0]          PRDATA_O,
	output logic                      PREADY_O,
	output logic                      PSLVERR_O,
	// Programmable terminals
	input  wire logic [N_IN-1:0]      PROGRAMMABLE_INPUT_TERMINAL_I,
	output logic      [N_OUT-1:0]     OUT_TERMINAL_O,
	// Amplifier status and alarm events
	input  wire logic                 POSITION_SETTLED_I,
	input  wire logic                 DYN_BRAKE_I,
	input  wire logic                 ZERO_DEVIATION_I,
	input  wire logic                 ZERO_SPEED_I,
	input  wire logic                 CURRENT_LIMIT_I,
	input  wire logic                 BRAKE_TIMING_I,
	input  wire logic [ALARM_N-2:0]   ALARM_EVENT_I,
	// Motion gate
	input  wire logic                 ROT_CMD_I,
	output logic                      ROT_CMD_O,
	output logic                      DRIVE_EN_O,
	output logic                      MAX_BRAKE_O,
	output logic                      ZERO_CMD_O,
	output logic                      READY_O,
	output logic                      ALARM_O,
	output logic      [FN_RSVD:0]     FUNC_O
);
	import seqio_pkg::*;

	typedef struct packed {
		logic [N_IN-1:0]        sync1;
		logic [N_IN-1:0]        sync2;
		logic                   clr_prev;
		logic [N_IN*IN_W-1:0]   in_pnd;
		logic [N_OUT*OUT_W-1:0] out_pnd;
		logic [N_IN*IN_W-1:0]   in_act;
		logic [N_OUT*OUT_W-1:0] out_act;
		logic [ALARM_N-1:0]     alarm;
		logic                   dup_chk;
		logic [FN_RSVD:0]       fn;
		motion_t                ms;
		logic [N_OUT-1:0]       outs;
		logic                   rot;
		logic                   ready;
		logic [31:0]            rdata;
		logic                   slverr;
	} state_t;

	state_t q;
	state_t d;

	logic [FN_RSVD:0] raw;
	logic [FN_RSVD:0] assigned;
	logic [FN_RSVD:0] fn;
	logic [15:0]      st;
	logic             dup;
	logic             clr_edge;
	logic             rdy;
	logic             setup;
	logic             wr;
	logic             reboot;
	logic [4:0]       code_i;
	logic [4:0]       code_j;
	logic [3:0]       code_o;

	always_comb begin
		d = q;
		raw = '0;
		assigned = '0;
		fn = '0;
		st = '0;
		dup = 1'b0;
		code_i = '0;
		code_j = '0;
		code_o = '0;

		// Terminal pins are asynchronous to the core clock
		d.sync1 = PROGRAMMABLE_INPUT_TERMINAL_I;
		d.sync2 = q.sync1;

		// Route each synchronised terminal to its allocated function
		for (int t = 0; t < N_IN; t++) begin
			code_i = q.in_act[t*IN_W +: IN_W];
			for (int c = 1; c <= FN_LAST; c++) begin
				if (code_i == 5'(c)) begin
					raw[c] = raw[c] | q.sync2[t];
					assigned[c] = 1'b1;
				end
			end
			// Code 22 and above fall through the loop unmapped
		end

		// Unallocated functions take their fixed levels
		for (int c = 0; c <= FN_RSVD; c++) begin
			fn[c] = assigned[c] ? raw[c] : FN_DEFAULT[c];
		end

		// Same nonzero code on two terminals
		for (int i = 0; i < N_IN; i++) begin
			for (int j = 0; j < N_IN; j++) begin
				code_i = q.in_act[i*IN_W +: IN_W];
				code_j = q.in_act[j*IN_W +: IN_W];
				if (i < j && code_i != 5'h00 && code_i == code_j) begin
					dup = 1'b1;
				end
			end
		end

		// Alarm clear acts on the activating edge only
		d.clr_prev = fn[FN_CLEAR];
		clr_edge = fn[FN_CLEAR] & ~q.clr_prev;

		// Only the clearable classes drop; new events still win
		d.alarm = q.alarm & ~(clr_edge ? ALARM_CLEARABLE : 15'h0000);
		d.alarm[ALARM_N-2:0] = d.alarm[ALARM_N-2:0] | ALARM_EVENT_I;
		d.dup_chk = 1'b0;
		if (q.dup_chk && dup) begin
			d.alarm[ALARM_DUP] = 1'b1;
		end

		// Ready only with every permissive present
		rdy = fn[FN_SERVO_EN] & ~(|q.alarm) & fn[FN_POS_LIM]
			& fn[FN_NEG_LIM] & fn[FN_HALT];

		// Motion gate
		case (q.ms)
			MS_RUN, MS_HOLD: begin
				if (!fn[FN_SERVO_EN]) begin
					d.ms = ZERO_SPEED_I ? MS_COAST : MS_BRAKE;
				end else begin
					d.ms = rdy ? MS_RUN : MS_HOLD;
				end
			end
			MS_BRAKE: begin
				// Full effort until inside the zero-speed window
				if (ZERO_SPEED_I) begin
					d.ms = MS_COAST;
				end
			end
			MS_COAST: begin
				if (fn[FN_SERVO_EN]) begin
					d.ms = rdy ? MS_RUN : MS_HOLD;
				end
			end
			default: begin
				d.ms = MS_COAST;
			end
		endcase

		// Commands pass only in the running state
		// Ready is needed too, or a command slips out on entry to hold
		d.rot = ROT_CMD_I & (q.ms == MS_RUN) & fn[FN_SERVO_EN] & rdy;
		d.ready = rdy;
		d.fn = fn;

		// Status sources indexed by output code
		st[OC_READY]    = rdy;
		st[OC_SETTLE]   = POSITION_SETTLED_I;
		st[OC_FAULT_NO] = |q.alarm;
		st[OC_FAULT_NC] = ~(|q.alarm);
		st[OC_DYN_BRK]  = DYN_BRAKE_I;
		st[OC_LIMIT]    = ~fn[FN_POS_LIM] | ~fn[FN_NEG_LIM];
		st[OC_HALT]     = ~fn[FN_HALT];
		st[OC_ZERO_DEV] = ZERO_DEVIATION_I;
		st[OC_ZERO_SPD] = ZERO_SPEED_I;
		st[OC_CUR_LIM]  = CURRENT_LIMIT_I;
		st[OC_BRK_TIME] = BRAKE_TIMING_I;
		// Codes 0, 12 and 13 and above leave st low

		for (int o = 0; o < N_OUT; o++) begin
			code_o = q.out_act[o*OUT_W +: OUT_W];
			d.outs[o] = st[code_o];
		end

		// APB: answer latched in setup so access needs no wait state
		setup = PSEL_I & ~PENABLE_I;
		wr = PSEL_I & PENABLE_I & PWRITE_I & ~q.slverr;
		reboot = 1'b0;
		if (setup) begin
			d.rdata = '0;
			d.slverr = 1'b0;
			case (PADDR_I)
				OFS_CTRL:    d.rdata = '0;
				OFS_IN_PND:  d.rdata[N_IN*IN_W-1:0] = q.in_pnd;
				OFS_OUT_PND: d.rdata[N_OUT*OUT_W-1:0] = q.out_pnd;
				OFS_IN_ACT:  d.rdata[N_IN*IN_W-1:0] = q.in_act;
				OFS_OUT_ACT: d.rdata[N_OUT*OUT_W-1:0] = q.out_act;
				OFS_ALARM:   d.rdata[ALARM_N-1:0] = q.alarm;
				OFS_FUNC:    d.rdata[FN_RSVD:0] = q.fn;
				OFS_STAT: begin
					d.rdata[1:0] = q.ms;
					d.rdata[2] = q.ready;
					d.rdata[3] = q.dup_chk;
					d.rdata[4+:N_OUT] = q.outs;
				end
				default:     d.slverr = 1'b1;
			endcase
		end
		if (wr) begin
			case (PADDR_I)
				OFS_IN_PND:  d.in_pnd = PWDATA_I[N_IN*IN_W-1:0];
				OFS_OUT_PND: d.out_pnd = PWDATA_I[N_OUT*OUT_W-1:0];
				OFS_CTRL:    reboot = PWDATA_I[CTRL_REBOOT];
				default:     reboot = 1'b0;
			endcase
		end

		// Soft reboot stands for a power cycle: new allocation takes
		// effect, every alarm class drops, duplication is rechecked
		if (reboot) begin
			d.in_act = q.in_pnd;
			d.out_act = q.out_pnd;
			d.alarm = '0;
			d.alarm[ALARM_N-2:0] = ALARM_EVENT_I;
			d.dup_chk = 1'b1;
			d.ms = MS_COAST;
		end

		if (SRST_I) begin
			d = '0;
			d.in_pnd = IN_ALLOC_RST;
			d.in_act = IN_ALLOC_RST;
			d.out_pnd = OUT_ALLOC_RST;
			d.out_act = OUT_ALLOC_RST;
			d.fn = FN_DEFAULT;
			d.dup_chk = 1'b1;
			d.ms = MS_COAST;
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		q <= d;
	end

	assign PRDATA_O = q.rdata;
	assign PREADY_O = 1'b1;
	assign PSLVERR_O = PSEL_I & PENABLE_I & q.slverr;
	assign OUT_TERMINAL_O = q.outs;
	assign ROT_CMD_O = q.rot;
	// Drive stays on while braking so the brake has torque behind it
	assign DRIVE_EN_O = (q.ms != MS_COAST);
	assign MAX_BRAKE_O = (q.ms == MS_BRAKE);
	assign ZERO_CMD_O = (q.ms == MS_HOLD);
	assign READY_O = q.ready;
	assign ALARM_O = |q.alarm;
	assign FUNC_O = q.fn;

endmodule : sequence_io_gate

// File: test/host_ctrl.sv
// Host controller model driving the programmable input terminals
module host_ctrl (
	input  wire logic       clk_i,
	input  wire logic [4:0] want_i,
	output logic      [4:0] pins_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pins change just after an edge, as a real contact would, unsynchronised
	always_ff @(posedge clk_i) begin
		pins_o <= want_i;
	end
endmodule : host_ctrl

// File: test/seqio_props.sv
// Concurrent checks on the sequence terminal and servo gate ports
module seqio_props
	import seqio_pkg::*;
(
	// Clock and reset
	input wire logic               REF_CLK_I,
	input wire logic               SRST_I,
	// Observed ports
	input wire logic               PSEL_I,
	input wire logic               PENABLE_I,
	input wire logic               PWRITE_I,
	input wire logic [FN_RSVD:0]   FUNC_O,
	input wire logic [ALARM_N-2:0] ALARM_EVENT_I,
	input wire logic               ZERO_SPEED_I,
	input wire logic               ROT_CMD_I,
	input wire logic               ROT_CMD_O,
	input wire logic               DRIVE_EN_O,
	input wire logic               MAX_BRAKE_O,
	input wire logic               ZERO_CMD_O,
	input wire logic               READY_O,
	input wire logic               ALARM_O
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (SRST_I);
	a_ready_perm: assert property (READY_O |-> FUNC_O[1] && FUNC_O[3]
		&& FUNC_O[4] && FUNC_O[5]) else $error("ready without permits");
	a_rot_gate: assert property (ROT_CMD_O |-> $past(ROT_CMD_I)
		&& $past(DRIVE_EN_O && !MAX_BRAKE_O && !ZERO_CMD_O))
		else $error("rotation passed outside run");
	a_coast_after: assert property (MAX_BRAKE_O && ZERO_SPEED_I
		|=> !DRIVE_EN_O) else $error("no coast at zero speed");
	a_brake_drive: assert property (MAX_BRAKE_O |-> DRIVE_EN_O
		&& !ZERO_CMD_O) else $error("brake without drive");
	a_hold_stop: assert property (ZERO_CMD_O |-> !READY_O
		&& !ROT_CMD_O) else $error("hold while ready");
	a_alarm_latch: assert property (|ALARM_EVENT_I |=> ALARM_O)
		else $error("alarm event not latched");
	a_level_noclr: assert property (ALARM_O && FUNC_O[2]
		&& $past(FUNC_O[2]) && !(PSEL_I && PENABLE_I && PWRITE_I)
		|=> ALARM_O) else $error("clear level dropped alarm");
	a_reset_dflt: assert property ($past(SRST_I) |-> FUNC_O[1]
		&& !FUNC_O[2] && FUNC_O[3] && FUNC_O[4])
		else $error("bad default functions");
	c_ready: cover property (READY_O);
	c_brake: cover property (MAX_BRAKE_O);
	c_rot: cover property (ROT_CMD_O);
endmodule : seqio_props

bind sequence_io_gate seqio_props u_props (.*);

// File: test/testbench.sv
// Self-checking bench for the sequence terminal and servo gate block
module testbench;
	import seqio_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic REF_CLK_I = 0, SRST_I = 1, PSEL_I = 0, PENABLE_I = 0, PWRITE_I = 0;
	logic [11:0] PADDR_I = 0;
	logic [31:0] PWDATA_I = 0, PRDATA_O, rd;
	logic PREADY_O, PSLVERR_O, er, ROT_CMD_I = 0, ROT_CMD_O, DRIVE_EN_O;
	logic POSITION_SETTLED_I = 0, DYN_BRAKE_I = 0, ZERO_DEVIATION_I = 0;
	logic ZERO_SPEED_I = 0, CURRENT_LIMIT_I = 0, BRAKE_TIMING_I = 0;
	logic [13:0] ALARM_EVENT_I = 0;
	logic [4:0] want = 0, PROGRAMMABLE_INPUT_TERMINAL_I;
	logic [3:0] OUT_TERMINAL_O;
	logic MAX_BRAKE_O, ZERO_CMD_O, READY_O, ALARM_O;
	logic [22:0] FUNC_O;
	int err_total = 0, total_checks = 0, cycles = 0;
	always #4 REF_CLK_I = ~REF_CLK_I;
	host_ctrl u_host (.clk_i(REF_CLK_I), .want_i(want),
		.pins_o(PROGRAMMABLE_INPUT_TERMINAL_I));
	sequence_io_gate u_dut (.*);
	task close_out;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : close_out
	always @(posedge REF_CLK_I) begin
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			close_out();
		end
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task wt(input int n);
		repeat (n) @(posedge REF_CLK_I);
		#1;
	endtask : wt
	// Hold the request until pready is seen; read data taken at that edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge REF_CLK_I);
		PSEL_I <= 1;
		PWRITE_I <= w;
		PADDR_I <= a;
		PWDATA_I <= d;
		@(posedge REF_CLK_I);
		PENABLE_I <= 1;
		do @(posedge REF_CLK_I); while (PREADY_O !== 1'b1);
		rd = PRDATA_O;
		er = PSLVERR_O;
		PSEL_I <= 0;
		PENABLE_I <= 0;
	endtask : apb
	task rot;
		ROT_CMD_I <= 1;
		@(posedge REF_CLK_I);
		ROT_CMD_I <= 0;
		#1;
	endtask : rot
	task s_defaults;
		apb(0, OFS_IN_ACT, 0);
		chk("in_alloc", 32'h41, rd);
		apb(0, OFS_OUT_ACT, 0);
		chk("out_alloc", 32'h421, rd);
		apb(0, 12'h040, 0);
		chk("slverr", 1, er);
	endtask : s_defaults
	task s_run;
		want <= 5'h01;
		POSITION_SETTLED_I <= 1;
		wt(6);
		chk("ready", 1, READY_O);
		chk("outs", 4'h7, OUT_TERMINAL_O);
		rot();
		chk("rot_run", 1, ROT_CMD_O);
	endtask : s_run
	task s_drop;
		want <= 5'h00;
		wt(5);
		chk("brake", 1, MAX_BRAKE_O);
		rot();
		chk("rot_off", 0, ROT_CMD_O);
		ZERO_SPEED_I <= 1;
		wt(2);
		chk("coast", 0, DRIVE_EN_O);
	endtask : s_drop
	task s_alarm;
		ALARM_EVENT_I <= 14'h0fff;
		wt(1);
		ALARM_EVENT_I <= 0;
		want <= 5'h02;
		wt(6);
		apb(0, OFS_ALARM, 0);
		chk("alarm_edge", 32'h800, rd);
		ALARM_EVENT_I <= 14'h0001;
		wt(1);
		ALARM_EVENT_I <= 0;
		wt(3);
		apb(0, OFS_ALARM, 0);
		chk("alarm_level", 32'h801, rd);
	endtask : s_alarm
	// Duplicate code 3, reserved codes, then a reboot to apply them
	task s_realloc;
		apb(1, OFS_IN_PND, 32'h5 | 32'h3 << 5 | 32'h3 << 10 | 32'h16 << 15
			| 32'h15 << 20);
		apb(1, OFS_OUT_PND, 32'h6 | 32'h7 << 4 | 32'hc << 8 | 32'h3 << 12);
		want <= 5'h10;
		apb(1, OFS_CTRL, 1);
		wt(6);
		apb(0, OFS_ALARM, 0);
		chk("dup", 32'h4000, rd);
		chk("func", 32'h200112, FUNC_O);
		chk("outs2", 4'hb, OUT_TERMINAL_O);
		chk("hold", 1, ZERO_CMD_O);
	endtask : s_realloc
	// Remaining status codes, two allocations applied by reboot
	task s_status;
		apb(1, OFS_OUT_PND, 32'h5 | 32'h8 << 4 | 32'h9 << 8 | 32'hb << 12);
		DYN_BRAKE_I <= 1;
		BRAKE_TIMING_I <= 1;
		apb(1, OFS_CTRL, 1);
		wt(3);
		chk("outs3", 4'hd, OUT_TERMINAL_O);
		apb(1, OFS_OUT_PND, 32'ha);
		CURRENT_LIMIT_I <= 1;
		apb(1, OFS_CTRL, 1);
		wt(3);
		chk("outs4", 4'h1, OUT_TERMINAL_O);
	endtask : s_status
	initial begin
		repeat (16) @(posedge REF_CLK_I);
		SRST_I <= 0;
		s_defaults();
		s_run();
		s_drop();
		s_alarm();
		s_realloc();
		s_status();
		close_out();
	end
endmodule : testbench
